// ===== pss_pkg.sv
// Shared constants, types and decoding for the pressure sensor command sequencer
package pss_pkg;
	// Measurement and read command bytes
	localparam logic [7:0] CMD_SINGLE = 8'hAA;
	localparam logic [7:0] CMD_AVG2   = 8'hAC;
	localparam logic [7:0] CMD_AVG4   = 8'hAD;
	localparam logic [7:0] CMD_AVG8   = 8'hAE;
	localparam logic [7:0] CMD_AVG16  = 8'hAF;
	localparam logic [7:0] CMD_READ   = 8'hF0;
	// Averaging passes as a power of two
	localparam logic [2:0] SHIFT_1  = 3'h0;
	localparam logic [2:0] SHIFT_2  = 3'h1;
	localparam logic [2:0] SHIFT_4  = 3'h2;
	localparam logic [2:0] SHIFT_8  = 3'h3;
	localparam logic [2:0] SHIFT_16 = 3'h4;
	// Frame layout
	localparam logic [3:0] REC_BYTES     = 4'h7;
	localparam logic [3:0] SPI_CMD_BYTES = 4'h3;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	// Status byte
	localparam int ST_POWER_BIT = 6;
	localparam int ST_BUSY_BIT  = 5;
	// Arbitrary bus address, not tied to any product
	localparam logic [6:0] I2C_ADDR = 7'h2A;
	// Synchronised pins {sclk, ss_n, mosi, scl, sda} and their idle levels
	localparam int PIN_SCLK = 4;
	localparam int PIN_SS_N = 3;
	localparam int PIN_MOSI = 2;
	localparam int PIN_SCL  = 1;
	localparam int PIN_SDA  = 0;
	localparam logic [4:0] PIN_RST = 5'h0B;
	// Converter input multiplexer
	localparam logic [1:0] MUX_P = 2'h0;
	localparam logic [1:0] MUX_T = 2'h1;
	localparam logic [1:0] MUX_Z = 2'h2;
	localparam int COMP_FRAC = 16;
	typedef enum {LOCK_NONE, LOCK_SPI, LOCK_I2C} pss_lock_t;

	// Returns {valid, shift}; valid only for measurement commands
	function automatic logic [3:0] cmd_decode(input logic [7:0] b);
		unique case (b)
			CMD_SINGLE: cmd_decode = {1'b1, SHIFT_1};
			CMD_AVG2:   cmd_decode = {1'b1, SHIFT_2};
			CMD_AVG4:   cmd_decode = {1'b1, SHIFT_4};
			CMD_AVG8:   cmd_decode = {1'b1, SHIFT_8};
			CMD_AVG16:  cmd_decode = {1'b1, SHIFT_16};
			default:    cmd_decode = 4'h0;
		endcase
	endfunction
endpackage

// ===== pss_meas_cycle.sv
// Measurement cycle engine: multiplexed conversions, averaging and compensation
`timescale 1ns/1ps
module pss_meas_cycle #(
	parameter logic signed [24:0] OFFSET  = 25'sh0000000,
	parameter logic signed [24:0] SPAN    = 25'sh0000000,
	parameter logic signed [24:0] TC_SPAN = 25'sh0000000,
	parameter logic signed [24:0] TC_OFF  = 25'sh0000000,
	parameter logic signed [24:0] TC_OFF2 = 25'sh0000000,
	parameter logic signed [24:0] LIN     = 25'sh0000000
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Command
	input  wire logic        i_start,
	input  wire logic [2:0]  i_shift,
	output logic             o_done,
	// Converter
	output logic             o_adc_start,
	output logic [1:0]       o_adc_mux,
	input  wire logic        i_adc_done,
	input  wire logic [23:0] i_adc_data,
	// Results
	output logic [23:0]      o_pressure,
	output logic [23:0]      o_temp
);
	typedef enum {M_IDLE, M_CONV, M_WAIT, M_COMP} pss_meas_st_t;
	pss_meas_st_t      state;
	logic [4:0]        passes_left;
	logic [2:0]        shift;
	logic [23:0]       raw_p;
	logic [23:0]       raw_t;
	logic signed [28:0] acc_p;
	logic signed [28:0] acc_t;
	logic signed [24:0] avg_p;
	logic signed [24:0] avg_t;
	logic signed [27:0] comp_p;

	localparam int COMP_FRAC_HI = pss_pkg::COMP_FRAC + 24;
	function automatic logic signed [24:0] term(input logic signed [24:0] x, input logic signed [24:0] k);
		logic signed [49:0] pr;
		pr = x * k;
		term = pr[COMP_FRAC_HI:pss_pkg::COMP_FRAC];
	endfunction

	function automatic logic [23:0] sat24(input logic signed [27:0] v);
		if (v < 0)
			sat24 = 24'h000000;
		else if (v > 28'sh0FFFFFF)
			sat24 = 24'hFFFFFF;
		else
			sat24 = v[23:0];
	endfunction

	always_comb begin
		avg_p = 25'(acc_p >>> shift);
		avg_t = 25'(acc_t >>> shift);
		// Span, offset, their temperature terms, second order offset and linearity
		comp_p = 28'(avg_p) + 28'(term(avg_p, SPAN)) + 28'(OFFSET) + 28'(term(term(avg_p, avg_t), TC_SPAN))
			+ 28'(term(avg_t, TC_OFF)) + 28'(term(term(avg_t, avg_t), TC_OFF2)) + 28'(term(term(avg_p, avg_p), LIN));
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= M_IDLE;
			passes_left <= 5'h00;
			shift <= 3'h0;
			o_adc_mux <= pss_pkg::MUX_P;
			raw_p <= 24'h000000;
			raw_t <= 24'h000000;
			acc_p <= 29'sh0000000;
			acc_t <= 29'sh0000000;
		end else begin
			unique case (state)
				M_IDLE: if (i_start) begin
					passes_left <= 5'(5'h01 << i_shift);
					shift <= i_shift;
					o_adc_mux <= pss_pkg::MUX_P;
					acc_p <= 29'sh0000000;
					acc_t <= 29'sh0000000;
					state <= M_CONV;
				end
				M_CONV: state <= M_WAIT;
				M_WAIT: if (i_adc_done) begin
					state <= M_CONV;
					// Pressure, temperature, then zero through the one converter
					unique case (o_adc_mux)
						pss_pkg::MUX_P: begin
							raw_p <= i_adc_data;
							o_adc_mux <= pss_pkg::MUX_T;
						end
						pss_pkg::MUX_T: begin
							raw_t <= i_adc_data;
							o_adc_mux <= pss_pkg::MUX_Z;
						end
						default: begin
							acc_p <= acc_p + 29'($signed({1'b0, raw_p}) - $signed({1'b0, i_adc_data}));
							acc_t <= acc_t + 29'($signed({1'b0, raw_t}) - $signed({1'b0, i_adc_data}));
							o_adc_mux <= pss_pkg::MUX_P;
							passes_left <= passes_left - 5'h01;
							if (passes_left == 5'h01)
								state <= M_COMP;
						end
					endcase
				end
				M_COMP: state <= M_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_adc_start <= 1'b0;
			o_done <= 1'b0;
			o_pressure <= 24'h000000;
			o_temp <= 24'h000000;
		end else begin
			o_adc_start <= (state == M_CONV);
			o_done <= (state == M_COMP);
			if (state == M_COMP) begin
				o_pressure <= sat24(comp_p);
				o_temp <= sat24(28'(avg_t));
			end
		end
	end
endmodule // pss_meas_cycle

// ===== pss_sequencer.sv
// Sensor command sequencer: interface lock, SPI and I2C slaves, measurement control
// Behaviour
// - Five measurement commands: single, and averages of 2, 4, 8, 16.
// - A measurement command received while idle wakes the device into active and starts a cycle.
// - Averaging commands repeat the cycle the selected number of times.
// - Single command runs exactly one cycle.
// - After results reach the I/O side the device returns to idle.
// - Idle device starts no conversion until another measurement command.
// - Data read returns seven bytes of status and results over SPI, converter idle; over I2C only the leading status byte reads back intact.
// - Status may be read at any time, including while measuring.
// - Each cycle converts pressure, temperature reference, then zero reference.
// - One converter behind an input multiplexer selecting the source.
// - Pressure gets span, offset, temperature, second order and linearity correction.
// - Slave select driven low locks the interface to SPI until power off.
// - Otherwise valid I2C address plus command locks the interface to I2C.
// - Record is status byte, 24-bit pressure, then 24-bit temperature.
// - Status bit 5 is one while busy, zero when ready.
`timescale 1ns/1ps
module pss_sequencer (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// SPI pins
	input  wire logic        i_spi_sclk,
	input  wire logic        i_spi_ss_n,
	input  wire logic        i_spi_mosi,
	output logic             o_spi_miso,
	output logic             o_spi_miso_oe,
	// I2C pins
	input  wire logic        i_i2c_scl,
	input  wire logic        i_i2c_sda,
	output logic             o_i2c_sda,
	output logic             o_i2c_sda_oe,
	// Converter
	output logic             o_adc_start,
	output logic [1:0]       o_adc_mux,
	input  wire logic        i_adc_done,
	input  wire logic [23:0] i_adc_data,
	// State
	output logic             o_active,
	output logic             o_lock_spi,
	output logic             o_lock_i2c
);
	typedef enum {I_IDLE, I_ADDR, I_WRITE, I_ACK, I_READ, I_RACK} pss_i2c_st_t;
	logic [4:0]        pins_meta;
	logic [4:0]        pins;
	logic [4:0]        pins_d;
	pss_pkg::pss_lock_t lock;
	logic              spi_ok;
	logic              i2c_ok;
	logic [7:0]        status;
	logic [23:0]       pressure;
	logic [23:0]       temp;
	logic              meas_go;
	logic [2:0]        meas_shift;
	logic              meas_done;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              scl_rise;
	logic              scl_fall;
	logic              i2c_start;
	logic              i2c_stop;
	// SPI slave state
	logic [2:0]        spi_bit;
	logic [3:0]        spi_idx;
	logic [7:0]        spi_rx;
	logic [7:0]        spi_tx;
	logic [7:0]        spi_cmd;
	logic              spi_go;
	// I2C slave state
	pss_i2c_st_t       i2c_st;
	logic [3:0]        i2c_bit;
	logic [3:0]        i2c_idx;
	logic [7:0]        i2c_sh;
	logic              i2c_rw;
	logic              i2c_acked;
	logic              i2c_go;
	logic              i2c_seen;
	logic [3:0]        spi_dec;
	logic [3:0]        i2c_dec;
	logic [7:0]        spi_rec;
	logic [7:0]        i2c_rec;

	// Record byte by index: status, pressure, temperature, MSB first
	function automatic logic [7:0] rec_byte(input logic [3:0] idx, input logic [7:0] st,
		input logic [23:0] p, input logic [23:0] t);
		unique case (idx)
			4'h0: rec_byte = st;
			4'h1: rec_byte = p[23:16];
			4'h2: rec_byte = p[15:8];
			4'h3: rec_byte = p[7:0];
			4'h4: rec_byte = t[23:16];
			4'h5: rec_byte = t[15:8];
			4'h6: rec_byte = t[7:0];
			default: rec_byte = 8'h00;
		endcase
	endfunction

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pins_meta <= pss_pkg::PIN_RST;
			pins <= pss_pkg::PIN_RST;
			pins_d <= pss_pkg::PIN_RST;
		end else begin
			pins_meta <= {i_spi_sclk, i_spi_ss_n, i_spi_mosi, i_i2c_scl, i_i2c_sda};
			pins <= pins_meta;
			pins_d <= pins;
		end
	end

	always_comb begin
		sclk_rise = pins[pss_pkg::PIN_SCLK] & ~pins_d[pss_pkg::PIN_SCLK];
		sclk_fall = ~pins[pss_pkg::PIN_SCLK] & pins_d[pss_pkg::PIN_SCLK];
		scl_rise = pins[pss_pkg::PIN_SCL] & ~pins_d[pss_pkg::PIN_SCL];
		scl_fall = ~pins[pss_pkg::PIN_SCL] & pins_d[pss_pkg::PIN_SCL];
		i2c_start = pins[pss_pkg::PIN_SCL] & pins_d[pss_pkg::PIN_SCL] & pins_d[pss_pkg::PIN_SDA] & ~pins[pss_pkg::PIN_SDA];
		i2c_stop = pins[pss_pkg::PIN_SCL] & pins_d[pss_pkg::PIN_SCL] & ~pins_d[pss_pkg::PIN_SDA] & pins[pss_pkg::PIN_SDA];
		spi_ok = (lock != pss_pkg::LOCK_I2C);
		i2c_ok = (lock != pss_pkg::LOCK_SPI);
		status = 8'h00;
		status[pss_pkg::ST_POWER_BIT] = 1'b1;
		status[pss_pkg::ST_BUSY_BIT] = o_active;
		spi_dec = pss_pkg::cmd_decode(spi_cmd);
		i2c_dec = pss_pkg::cmd_decode(i2c_sh);
		spi_rec = rec_byte(spi_idx, status, pressure, temp);
		i2c_rec = rec_byte(i2c_idx, status, pressure, temp);
	end

	// Interface lock, held until power is removed
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			lock <= pss_pkg::LOCK_NONE;
		else if (lock == pss_pkg::LOCK_NONE) begin
			if (!pins[pss_pkg::PIN_SS_N])
				lock <= pss_pkg::LOCK_SPI;
			else if (i2c_seen)
				lock <= pss_pkg::LOCK_I2C;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_lock_spi <= 1'b0;
			o_lock_i2c <= 1'b0;
		end else begin
			o_lock_spi <= (lock == pss_pkg::LOCK_SPI);
			o_lock_i2c <= (lock == pss_pkg::LOCK_I2C);
		end
	end

	// SPI slave, mode 0: sample on rising clock, shift out on falling clock
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			spi_bit <= 3'h0;
			spi_idx <= 4'h0;
			spi_rx <= 8'h00;
			spi_tx <= 8'h00;
			spi_cmd <= 8'h00;
			spi_go <= 1'b0;
			o_spi_miso <= 1'b0;
			o_spi_miso_oe <= 1'b0;
		end else begin
			spi_go <= 1'b0;
			o_spi_miso_oe <= spi_ok & ~pins[pss_pkg::PIN_SS_N];
			if (!spi_ok || pins[pss_pkg::PIN_SS_N]) begin
				// Frame end: a three byte measurement command starts a measurement
				if (spi_ok && !pins_d[pss_pkg::PIN_SS_N] && spi_idx == pss_pkg::SPI_CMD_BYTES)
					spi_go <= spi_dec[3];
				spi_bit <= 3'h0;
				spi_idx <= 4'h0;
			end else if (pins_d[pss_pkg::PIN_SS_N]) begin
				// Status leads every frame, so a one byte read is a status read
				spi_tx <= rec_byte(4'h0, status, pressure, temp);
				o_spi_miso <= status[7];
			end else if (sclk_rise) begin
				spi_rx <= {spi_rx[6:0], pins[pss_pkg::PIN_MOSI]};
				spi_bit <= spi_bit + 3'h1;
				if (spi_bit == pss_pkg::BIT_LAST) begin
					if (spi_idx == 4'h0)
						spi_cmd <= {spi_rx[6:0], pins[pss_pkg::PIN_MOSI]};
					if (spi_idx != 4'hF)
						spi_idx <= spi_idx + 4'h1;
				end
			end else if (sclk_fall) begin
				if (spi_bit == 3'h0) begin
					spi_tx <= spi_rec;
					o_spi_miso <= spi_rec[7];
				end else begin
					spi_tx <= {spi_tx[6:0], 1'b0};
					o_spi_miso <= spi_tx[6];
				end
			end
		end
	end

	// I2C slave: open drain, the enable pulls the data line low
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			i2c_st <= I_IDLE;
			i2c_bit <= 4'h0;
			i2c_idx <= 4'h0;
			i2c_sh <= 8'h00;
			i2c_rw <= 1'b0;
			i2c_acked <= 1'b0;
			i2c_go <= 1'b0;
			i2c_seen <= 1'b0;
			o_i2c_sda <= 1'b0;
			o_i2c_sda_oe <= 1'b0;
		end else begin
			i2c_go <= 1'b0;
			i2c_seen <= 1'b0;
			o_i2c_sda <= 1'b0;
			if (!i2c_ok || i2c_stop) begin
				i2c_st <= I_IDLE;
				o_i2c_sda_oe <= 1'b0;
			end else if (i2c_start) begin
				i2c_st <= I_ADDR;
				i2c_bit <= 4'h0;
				o_i2c_sda_oe <= 1'b0;
			end else begin
				unique case (i2c_st)
					I_IDLE: o_i2c_sda_oe <= 1'b0;
					I_ADDR, I_WRITE: if (scl_rise) begin
						i2c_sh <= {i2c_sh[6:0], pins[pss_pkg::PIN_SDA]};
						i2c_bit <= i2c_bit + 4'h1;
					end else if (scl_fall && i2c_bit == 4'h8) begin
						i2c_bit <= 4'h0;
						if (i2c_st == I_ADDR && i2c_sh[7:1] != pss_pkg::I2C_ADDR)
							i2c_st <= I_IDLE;
						else begin
							i2c_st <= I_ACK;
							o_i2c_sda_oe <= 1'b1;
							if (i2c_st == I_ADDR) begin
								i2c_rw <= i2c_sh[0];
								i2c_idx <= 4'h0;
								i2c_seen <= i2c_sh[0];
							end else begin
								i2c_seen <= 1'b1;
								i2c_go <= i2c_dec[3];
							end
						end
					end
					I_ACK: if (scl_fall) begin
						if (i2c_rw) begin
							i2c_st <= I_READ;
							i2c_sh <= i2c_rec;
							o_i2c_sda_oe <= ~i2c_rec[7];
						end else begin
							i2c_st <= I_WRITE;
							o_i2c_sda_oe <= 1'b0;
						end
					end
					I_READ: if (scl_fall) begin
						if (i2c_bit == 4'h7) begin
							i2c_st <= I_RACK;
							o_i2c_sda_oe <= 1'b0;
						end else begin
							i2c_bit <= i2c_bit + 4'h1;
							i2c_sh <= {i2c_sh[6:0], 1'b0};
							o_i2c_sda_oe <= ~i2c_sh[6];
						end
					end
					I_RACK: if (scl_rise) begin
						i2c_acked <= ~pins[pss_pkg::PIN_SDA];
						if (i2c_idx != 4'hF)
							i2c_idx <= i2c_idx + 4'h1;
					end else if (scl_fall) begin
						i2c_bit <= 4'h0;
						i2c_st <= i2c_acked ? I_ACK : I_IDLE;
					end
				endcase
			end
		end
	end

	// Idle/active sequencing; commands arriving while active are dropped
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_active <= 1'b0;
			meas_go <= 1'b0;
			meas_shift <= 3'h0;
		end else begin
			meas_go <= 1'b0;
			if (!o_active && !meas_go && (spi_go || i2c_go)) begin
				meas_go <= 1'b1;
				meas_shift <= spi_go ? spi_dec[2:0] : i2c_dec[2:0];
			end
			if (meas_go)
				o_active <= 1'b1;
			else if (meas_done)
				o_active <= 1'b0;
		end
	end

	pss_meas_cycle u_meas (
		.i_clock    (i_clock),
		.i_rst      (i_rst),
		.i_start    (meas_go),
		.i_shift    (meas_shift),
		.o_done     (meas_done),
		.o_adc_start(o_adc_start),
		.o_adc_mux  (o_adc_mux),
		.i_adc_done (i_adc_done),
		.i_adc_data (i_adc_data),
		.o_pressure (pressure),
		.o_temp     (temp)
	);

	// Conversion starts counted per measurement, for checking
	logic [6:0] conv_cnt;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			conv_cnt <= 7'h00;
		else if (meas_go)
			conv_cnt <= 7'h00;
		else if (o_adc_start)
			conv_cnt <= conv_cnt + 7'h01;
	end

	sequence s_cmd_accept;
		!o_active && meas_go;
	endsequence
	sequence s_wake;
		o_active ##1 o_adc_start;
	endsequence
	sequence s_finish;
		meas_done ##1 !o_active;
	endsequence

	AST_WAKE: assert property (@(posedge i_clock) disable iff (i_rst) s_cmd_accept |=> s_wake)
		else $error("measurement command did not start a conversion");
	AST_IDLE_QUIET: assert property (@(posedge i_clock) disable iff (i_rst) !o_active |-> !o_adc_start)
		else $error("conversion started while idle");
	AST_PASS_COUNT: assert property (@(posedge i_clock) disable iff (i_rst)
		meas_done |-> conv_cnt == 7'(7'h03 << meas_shift))
		else $error("conversion count does not match averaging");
	AST_SINGLE: assert property (@(posedge i_clock) disable iff (i_rst)
		meas_done && meas_shift == pss_pkg::SHIFT_1 |-> conv_cnt == 7'h03)
		else $error("single command did not run one cycle");
	AST_RETURN_IDLE: assert property (@(posedge i_clock) disable iff (i_rst) o_active && meas_done |-> ##0 s_finish)
		else $error("device stayed active after results");
	AST_MUX_ORDER: assert property (@(posedge i_clock) disable iff (i_rst)
		o_adc_start && o_adc_mux == pss_pkg::MUX_P |=> o_adc_mux == pss_pkg::MUX_P [*2] ##[1:1000] o_adc_mux == pss_pkg::MUX_T)
		else $error("pressure not followed by temperature");
	AST_BUSY_BIT: assert property (@(posedge i_clock) disable iff (i_rst)
		status[pss_pkg::ST_BUSY_BIT] == o_active && status[pss_pkg::ST_POWER_BIT])
		else $error("status busy bit wrong");
	AST_SPI_LOCK: assert property (@(posedge i_clock) disable iff (i_rst)
		lock == pss_pkg::LOCK_NONE && !pins[pss_pkg::PIN_SS_N] |=> lock == pss_pkg::LOCK_SPI [*2])
		else $error("slave select did not lock SPI");
	AST_I2C_LOCK: assert property (@(posedge i_clock) disable iff (i_rst)
		lock == pss_pkg::LOCK_I2C |=> lock == pss_pkg::LOCK_I2C)
		else $error("I2C lock lost");
	AST_IGNORE_OTHER: assert property (@(posedge i_clock) disable iff (i_rst)
		lock == pss_pkg::LOCK_SPI |=> !o_i2c_sda_oe)
		else $error("I2C answered after SPI lock");
endmodule // pss_sequencer

// ===== pss_host_model.sv
// SPI host model that frames mode 0 transfers on its own link clock
`timescale 1ns/1ps
module pss_host_model (
	// SPI pins
	output logic      o_sclk,
	output logic      o_ss_n,
	output logic      o_mosi,
	input  wire logic i_miso,
	input  wire logic i_miso_oe
);
	initial begin
		o_sclk = 1'b0;
		o_ss_n = 1'b1;
		o_mosi = 1'b0;
	end

	// Shifts n bytes MSB first at 160 ns per bit; undriven MISO reads as unknown
	task automatic xfer(input int n, input logic [55:0] tx, output logic [55:0] rx);
		rx = '0;
		o_ss_n = 1'b0;
		#170;
		for (int i = 0; i < 8 * n; i++) begin
			o_mosi = tx[55 - i];
			#80;
			o_sclk = 1'b1;
			rx[55 - i] = i_miso_oe ? i_miso : 1'bx;
			#80;
			o_sclk = 1'b0;
		end
		#80;
		o_ss_n = 1'b1;
		// Released data line must not keep its last bit
		o_mosi = ~o_mosi;
		#200;
	endtask
endmodule // pss_host_model

// ===== pss_sequencer_tb.sv
// Self-checking bench for the sensor command sequencer
`timescale 1ns/1ps
module pss_sequencer_tb;
	logic            i_clock;
	logic            i_rst;
	logic            i_i2c_scl;
	logic            sda_drv;
	logic            i_adc_done;
	logic [23:0]     i_adc_data;
	wire logic       sclk, ss_n, mosi, o_spi_miso, o_spi_miso_oe;
	wire logic       o_i2c_sda, o_i2c_sda_oe, o_adc_start, o_active, o_lock_spi, o_lock_i2c;
	wire logic [1:0] o_adc_mux;
	wire logic       i2c_wire;
	int              err_count, checked, cyc, n_start, adc_wait, n0;
	integer          seed;
	logic [23:0]     src [3];
	logic [55:0]     rx;
	logic            ack;

	// Open-drain data line with pull-up
	assign i2c_wire = sda_drv & ~o_i2c_sda_oe;

	pss_host_model host_i (.o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(o_spi_miso),
		.i_miso_oe(o_spi_miso_oe));

	pss_sequencer pss_sequencer_i (.i_clock(i_clock), .i_rst(i_rst), .i_spi_sclk(sclk),
		.i_spi_ss_n(ss_n), .i_spi_mosi(mosi), .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
		.i_i2c_scl(i_i2c_scl), .i_i2c_sda(i2c_wire), .o_i2c_sda(o_i2c_sda), .o_i2c_sda_oe(o_i2c_sda_oe),
		.o_adc_start(o_adc_start), .o_adc_mux(o_adc_mux), .i_adc_done(i_adc_done),
		.i_adc_data(i_adc_data), .o_active(o_active), .o_lock_spi(o_lock_spi), .o_lock_i2c(o_lock_i2c));

	initial i_clock = 1'b0;
	always #10 i_clock = ~i_clock;

	task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			end_sim();
		end
	end

	// Converter model: answers each start after a random delay with the selected source
	always @(posedge i_clock) begin
		i_adc_done <= 1'b0;
		if (adc_wait == 1) begin
			i_adc_done <= 1'b1;
			i_adc_data <= src[o_adc_mux];
		end
		if (adc_wait > 0)
			adc_wait--;
		if (o_adc_start === 1'b1) begin
			check("adc_mux", o_adc_mux, 56'(n_start % 3));
			n_start++;
			adc_wait = 4 + {$random(seed)} % 5;
		end
	end

	task automatic wait_active(input logic want);
		int k;
		k = 0;
		while (o_active !== want && k < 2000) begin
			@(posedge i_clock);
			k++;
		end
		check("active", o_active, 56'(want));
	endtask

	task automatic i2c_bit(input logic b, output logic seen);
		@(posedge i_clock) sda_drv <= b;
		repeat (3) @(posedge i_clock);
		i_i2c_scl <= 1'b1;
		repeat (4) @(posedge i_clock);
		#1 seen = i2c_wire;
		@(posedge i_clock) i_i2c_scl <= 1'b0;
	endtask

	task automatic i2c_byte(input logic [7:0] b, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--)
			i2c_bit(b[i], s);
		i2c_bit(1'b1, s);
		a = ~s;
	endtask

	task automatic i2c_start();
		@(posedge i_clock) sda_drv <= 1'b0;
		repeat (4) @(posedge i_clock);
		i_i2c_scl <= 1'b0;
	endtask

	task automatic i2c_stop();
		@(posedge i_clock) sda_drv <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_i2c_scl <= 1'b1;
		repeat (4) @(posedge i_clock);
		sda_drv <= 1'b1;
		repeat (8) @(posedge i_clock);
	endtask

	task automatic measure(input logic [7:0] cmd, input int shift);
		logic [23:0] p, t, z;
		z = 24'($random(seed)) & 24'h0FFFFF;
		p = z + (24'($random(seed)) & 24'h7FFFFF);
		t = z + (24'($random(seed)) & 24'h7FFFFF);
		src[0] = p;
		src[1] = t;
		src[2] = z;
		n0 = n_start;
		host_i.xfer(3, {cmd, 48'h0}, rx);
		wait_active(1'b1);
		if (shift > 0 && shift < 4) begin
			host_i.xfer(1, {8'hF0, 48'h0}, rx);
			check("busy status", rx[55:48], 56'h60);
		end
		if (shift == 4)
			host_i.xfer(3, {pss_pkg::CMD_SINGLE, 48'h0}, rx);
		wait_active(1'b0);
		check("starts", 56'(n_start - n0), 56'(3 << shift));
		host_i.xfer(7, {8'hF0, 48'h0}, rx);
		check("record", rx, {8'h40, p - z, t - z});
		check("idle starts", 56'(n_start - n0), 56'(3 << shift));
	endtask

	initial begin
		seed = 32'h9F6B;
		i_rst = 1'b1;
		i_i2c_scl = 1'b1;
		sda_drv = 1'b1;
		i_adc_done = 1'b0;
		i_adc_data = 24'h0;
		src = '{24'h0, 24'h0, 24'h0};
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		check("lock idle", {o_lock_spi, o_lock_i2c, o_active}, 56'h0);
		host_i.xfer(7, {8'hF0, 48'h0}, rx);
		check("reset record", rx, {8'h40, 48'h0});
		check("spi lock", {o_lock_spi, o_lock_i2c}, 56'h2);
		// Short measurement frame and a non-measurement code start nothing
		host_i.xfer(2, {pss_pkg::CMD_SINGLE, 48'h0}, rx);
		host_i.xfer(3, {8'hF0, 48'h0}, rx);
		repeat (40) @(posedge i_clock);
		check("refused", 56'(n_start), 56'h0);
		measure(pss_pkg::CMD_SINGLE, 0);
		measure(pss_pkg::CMD_AVG2, 1);
		measure(pss_pkg::CMD_AVG4, 2);
		measure(pss_pkg::CMD_AVG8, 3);
		measure(pss_pkg::CMD_AVG16, 4);
		i2c_start();
		i2c_byte({pss_pkg::I2C_ADDR, 1'b0}, ack);
		i2c_stop();
		check("i2c ignored", {ack, o_lock_i2c}, 56'h0);
		// Power cycle, then the first I2C command takes the lock
		@(posedge i_clock) i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		n0 = n_start;
		i2c_start();
		i2c_byte({pss_pkg::I2C_ADDR, 1'b0}, ack);
		check("addr ack", 56'(ack), 56'h1);
		i2c_byte(pss_pkg::CMD_AVG2, ack);
		i2c_stop();
		check("i2c lock", {ack, o_lock_i2c, o_lock_spi}, 56'h6);
		wait_active(1'b1);
		wait_active(1'b0);
		check("i2c starts", 56'(n_start - n0), 56'h6);
		host_i.xfer(1, {8'hF0, 48'h0}, rx);
		check("spi ignored", {rx[55:48], o_lock_spi}, {8'hxx, 1'b0});
		end_sim();
	end
endmodule // pss_sequencer_tb
